// >>> include/rtcam_pkg.sv
// Constants shared by the alarm match and control logic
`default_nettype none
package rtcam_pkg;
  // Register port geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [4:0] ALM_BASE_ADDR = 5'h07;
  localparam logic [4:0] ALM1_SEC_ADDR = 5'h07;
  localparam logic [4:0] ALM1_MIN_ADDR = 5'h08;
  localparam logic [4:0] ALM1_HOUR_ADDR = 5'h09;
  localparam logic [4:0] ALM1_DAY_ADDR = 5'h0a;
  localparam logic [4:0] ALM2_MIN_ADDR = 5'h0b;
  localparam logic [4:0] ALM2_HOUR_ADDR = 5'h0c;
  localparam logic [4:0] ALM2_DAY_ADDR = 5'h0d;
  localparam logic [4:0] CTRL_ADDR = 5'h0e;
  localparam logic [4:0] STAT_ADDR = 5'h0f;
  localparam int ALM_REGS = 7;
  // Alarm register fields
  localparam int MASK_BIT = 7;
  localparam int DYDT_BIT = 6;
  localparam int TIME_FIELD_W = 7;
  localparam int DAY_FIELD_W = 6;
  localparam logic [7:0] ALM2_SECONDS = 8'h00;
  localparam logic [7:0] ALM_RESET = 8'h00;
  // Control register
  localparam logic [7:0] CTRL_RESET = 8'h1c;
  localparam int CTRL_OSC_BIT = 7;
  localparam int CTRL_BBW_BIT = 6;
  localparam int CTRL_TEMP_CONVERT_REQUEST_BIT = 5;
  localparam int CTRL_IRQ_OR_WAVE_SELECT_BIT = 2;
  localparam int CTRL_ALARM2_IRQ_ENABLE_BIT = 1;
  localparam int CTRL_ALARM1_IRQ_ENABLE_BIT = 0;
  // Status register
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_A2F_BIT = 1;
  localparam int STAT_A1F_BIT = 0;
  // Timing
  localparam longint CLK_PERIOD_NS = 20;
  localparam longint HALF_SEC_NS = 500000000;
  localparam int HALF_SEC_CYCLES = int'(HALF_SEC_NS / CLK_PERIOD_NS);
  localparam int HALF_CNT_W = 25;
  // Conversion sequencer
  typedef enum logic [1:0] {CV_IDLE, CV_PERIODIC, CV_USER} rtcam_temp_convert_request_type;
endpackage
`default_nettype wire

// >>> rtl/rtcam_alarm_match.sv
// Field comparator for one time-of-day alarm
`default_nettype none
module rtcam_alarm_match
  import rtcam_pkg::*;
(
  // Programmed alarm bytes
  input wire logic [7:0] sec_alarm,
  input wire logic [7:0] min_alarm,
  input wire logic [7:0] hour_alarm,
  input wire logic [7:0] day_alarm,
  // Current timekeeping values
  input wire logic [7:0] cur_seconds,
  input wire logic [7:0] cur_minutes,
  input wire logic [7:0] cur_hours,
  input wire logic [7:0] cur_day,
  input wire logic [7:0] cur_date,
  // Result
  output logic hit
);
  logic sec_eq;
  logic min_eq;
  logic hour_eq;
  logic day_eq;
  logic [DAY_FIELD_W-1:0] day_ref;

  // [R2] Weekday or month-day source
  assign day_ref = day_alarm[DYDT_BIT] ? cur_day[DAY_FIELD_W-1:0] : cur_date[DAY_FIELD_W-1:0];
  assign sec_eq = sec_alarm[TIME_FIELD_W-1:0] == cur_seconds[TIME_FIELD_W-1:0];
  assign min_eq = min_alarm[TIME_FIELD_W-1:0] == cur_minutes[TIME_FIELD_W-1:0];
  assign hour_eq = hour_alarm[TIME_FIELD_W-1:0] == cur_hours[TIME_FIELD_W-1:0];
  assign day_eq = day_alarm[DAY_FIELD_W-1:0] == day_ref;

  // [R1] Masked field compare
  assign hit = (sec_alarm[MASK_BIT] | sec_eq) & (min_alarm[MASK_BIT] | min_eq)
    & (hour_alarm[MASK_BIT] | hour_eq) & (day_alarm[MASK_BIT] | day_eq);
endmodule
`default_nettype wire

// >>> rtl/rtcam_alarm_ctrl.sv
// Alarm match, control register and shared interrupt / 1Hz output
// Operation
// [R1] Bit 7 of every alarm byte masks its field; all clear means full match.
// [R2] Day/date selector bit 6: 0 compares date, 1 compares weekday.
// [R3] A matching alarm sets its status flag.
// [R4] Matches are tested once per second, at the time update.
// [R5] Alarm 1 masks choose every second, seconds, min+sec, h+m+s, or +day.
// [R6] Alarm 2 has no seconds: fires at second zero, mask patterns like alarm 1.
// [R7] Host programs only listed mask combinations; others are undefined.
// [R8] Control bit 7 stops the oscillator only on battery; resets to 0.
// [R9] A stopped oscillator freezes timekeeping and alarm updates.
// [R10] Control bit 6 keeps the wave on battery, else the output floats.
// [R11] Control bit 5 starts a conversion, reads 1 until it finishes.
// [R12] Compensation at most once per second; user request keeps periodic schedule.
// [R13] Control bits 4:3 store any value and do nothing.
// [R14] Control bit 2: 0 gives 1Hz wave, 1 gives alarm interrupt; resets 1.
// [R15] Flags set regardless of interrupt control and enables.
// [R16] Bit 1 lets alarm 2 flag interrupt when interrupt control is 1.
// [R17] Bit 0 lets alarm 1 flag interrupt when interrupt control is 1.
// [R18] Writing 0 clears a flag; writing 1 leaves it unchanged.
// [R19] Alarm 1 lives at 07h-0Ah, alarm 2 at 0Bh-0Dh.
// [R20] Interrupt output held low while an enabled flag stays set.
`default_nettype none
module rtcam_alarm_ctrl
  import rtcam_pkg::*;
#(
  parameter int HALF_SEC_COUNT = HALF_SEC_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port from the serial engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  // Current time from the calendar counters
  input wire logic [7:0] cur_seconds,
  input wire logic [7:0] cur_minutes,
  input wire logic [7:0] cur_hours,
  input wire logic [7:0] cur_day,
  input wire logic [7:0] cur_date,
  // Time base
  output logic sec_tick,
  output logic osc_run,
  // Power monitor pin, high while on battery
  input wire logic on_battery,
  // Temperature sensor and compensation
  output logic sensor_start,
  input wire logic sensor_done,
  output logic comp_update,
  // Open-drain interrupt / square wave pin
  output logic irq_wave_out_n_o,
  output logic irq_wave_out_n_oe_n
);
  logic [7:0] alarm_reg [ALM_REGS];
  logic [7:0] ctrl_reg;
  logic temp_convert_request_user_reg;
  logic alarm1_flag_reg;
  logic alarm2_flag_reg;
  logic batt_meta_reg;
  logic batt_sync_reg;
  logic [HALF_CNT_W-1:0] half_cnt_reg;
  logic wave_reg;
  logic eval_reg;
  logic alarm1_hit;
  logic alarm2_hit;
  logic half_tick;
  logic wr_stat;
  logic [2:0] alm_idx;
  rtcam_temp_convert_request_type temp_convert_request_state_reg;
  logic periodic_pending_reg;
  logic comp_done_sec_reg;
  logic comp_owed_reg;
  logic sensor_start_reg;
  logic comp_update_reg;
  logic comp_seen_reg;
  logic irq_active;
  logic out_reg;
  logic oe_n_reg;
  logic [DATA_W-1:0] rdata_reg;

  // Elaboration check on the half-second count
  if (HALF_SEC_COUNT < 2 || HALF_SEC_COUNT >= (1 << HALF_CNT_W))
  begin : g_bad_half_sec
    $error("HALF_SEC_COUNT out of range");
  end

  assign alm_idx = 3'(reg_addr - ALM_BASE_ADDR);
  assign wr_stat = reg_wr && reg_addr == STAT_ADDR;

  // Battery indication synchroniser
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      batt_meta_reg <= 1'b0;
      batt_sync_reg <= 1'b0;
    end
    else
    begin
      batt_meta_reg <= on_battery;
      batt_sync_reg <= batt_meta_reg;
    end
  end

  // [R8] Oscillator stops only on battery
  assign osc_run = !(batt_sync_reg && ctrl_reg[CTRL_OSC_BIT]);

  // [R9] Time base frozen while stopped
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      half_cnt_reg <= '0;
      wave_reg <= 1'b1;
    end
    else if (osc_run)
    begin
      if (half_tick)
      begin
        half_cnt_reg <= '0;
        wave_reg <= !wave_reg;
      end
      else
      begin
        half_cnt_reg <= half_cnt_reg + 1'b1;
      end
    end
  end

  assign half_tick = osc_run && half_cnt_reg == HALF_CNT_W'(HALF_SEC_COUNT - 1);
  assign sec_tick = half_tick && wave_reg;

  // [R4] Compare one cycle after the counters update
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      eval_reg <= 1'b0;
    end
    else
    begin
      eval_reg <= sec_tick;
    end
  end

  // [R5] Alarm 1 comparator
  rtcam_alarm_match u_alarm1 (
    .sec_alarm(alarm_reg[0]),
    .min_alarm(alarm_reg[1]),
    .hour_alarm(alarm_reg[2]),
    .day_alarm(alarm_reg[3]),
    .cur_seconds(cur_seconds),
    .cur_minutes(cur_minutes),
    .cur_hours(cur_hours),
    .cur_day(cur_day),
    .cur_date(cur_date),
    .hit(alarm1_hit)
  );

  // [R6] Alarm 2 comparator, seconds pinned to zero
  rtcam_alarm_match u_alarm2 (
    .sec_alarm(ALM2_SECONDS),
    .min_alarm(alarm_reg[4]),
    .hour_alarm(alarm_reg[5]),
    .day_alarm(alarm_reg[6]),
    .cur_seconds(cur_seconds),
    .cur_minutes(cur_minutes),
    .cur_hours(cur_hours),
    .cur_day(cur_day),
    .cur_date(cur_date),
    .hit(alarm2_hit)
  );

  // Alarm byte storage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < ALM_REGS; i++)
      begin
        alarm_reg[i] <= ALM_RESET;
      end
    end
    else if (reg_wr && reg_addr >= ALM1_SEC_ADDR && reg_addr <= ALM2_DAY_ADDR)
    begin
      alarm_reg[alm_idx] <= reg_wdata;
    end
  end

  // [R13] Control bits stored as written
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else if (reg_wr && reg_addr == CTRL_ADDR)
    begin
      ctrl_reg <= reg_wdata;
    end
  end

  // [R3] [R15] [R18] Flags: set wins, write 1 ignored
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      alarm1_flag_reg <= 1'b0;
      alarm2_flag_reg <= 1'b0;
    end
    else
    begin
      alarm1_flag_reg <= (eval_reg && osc_run && alarm1_hit)
        || (alarm1_flag_reg && !(wr_stat && !reg_wdata[STAT_A1F_BIT]));
      alarm2_flag_reg <= (eval_reg && osc_run && alarm2_hit)
        || (alarm2_flag_reg && !(wr_stat && !reg_wdata[STAT_A2F_BIT]));
    end
  end

  // [R11] User request held until its conversion ends
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      temp_convert_request_user_reg <= 1'b0;
    end
    else if (temp_convert_request_state_reg == CV_USER && sensor_done)
    begin
      temp_convert_request_user_reg <= 1'b0;
    end
    else if (reg_wr && reg_addr == CTRL_ADDR && reg_wdata[CTRL_TEMP_CONVERT_REQUEST_BIT])
    begin
      temp_convert_request_user_reg <= 1'b1;
    end
  end

  // [R12] Periodic conversion queued every second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      periodic_pending_reg <= 1'b0;
    end
    else if (sec_tick)
    begin
      periodic_pending_reg <= 1'b1;
    end
    else if (temp_convert_request_state_reg == CV_IDLE)
    begin
      periodic_pending_reg <= 1'b0;
    end
  end

  // Conversion sequencer, periodic work first
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      temp_convert_request_state_reg <= CV_IDLE;
      sensor_start_reg <= 1'b0;
    end
    else
    begin
      sensor_start_reg <= 1'b0;
      unique case (temp_convert_request_state_reg)
        CV_IDLE:
        begin
          if (periodic_pending_reg)
          begin
            temp_convert_request_state_reg <= CV_PERIODIC;
            sensor_start_reg <= 1'b1;
          end
          else if (temp_convert_request_user_reg)
          begin
            temp_convert_request_state_reg <= CV_USER;
            sensor_start_reg <= 1'b1;
          end
        end
        CV_PERIODIC, CV_USER:
        begin
          if (sensor_done)
          begin
            temp_convert_request_state_reg <= CV_IDLE;
          end
        end
      endcase
    end
  end

  // [R12] Compensation limited to once per second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      comp_done_sec_reg <= 1'b0;
      comp_owed_reg <= 1'b0;
      comp_update_reg <= 1'b0;
    end
    else
    begin
      comp_update_reg <= 1'b0;
      if (sec_tick)
      begin
        comp_done_sec_reg <= 1'b0;
      end
      if (temp_convert_request_state_reg != CV_IDLE && sensor_done)
      begin
        comp_owed_reg <= 1'b1;
      end
      if (comp_owed_reg && !comp_done_sec_reg && !sec_tick)
      begin
        comp_update_reg <= 1'b1;
        comp_done_sec_reg <= 1'b1;
        comp_owed_reg <= temp_convert_request_state_reg != CV_IDLE && sensor_done;
      end
    end
  end

  assign sensor_start = sensor_start_reg;
  assign comp_update = comp_update_reg;

  // [R16] [R17] [R20] Enabled flags drive the interrupt
  assign irq_active = ctrl_reg[CTRL_IRQ_OR_WAVE_SELECT_BIT]
    && ((alarm1_flag_reg && ctrl_reg[CTRL_ALARM1_IRQ_ENABLE_BIT])
    || (alarm2_flag_reg && ctrl_reg[CTRL_ALARM2_IRQ_ENABLE_BIT]));

  // [R10] [R14] Output role and battery float
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_reg <= 1'b1;
      oe_n_reg <= 1'b1;
    end
    else if (batt_sync_reg && !ctrl_reg[CTRL_BBW_BIT])
    begin
      out_reg <= 1'b1;
      oe_n_reg <= 1'b1;
    end
    else if (ctrl_reg[CTRL_IRQ_OR_WAVE_SELECT_BIT])
    begin
      out_reg <= !irq_active;
      oe_n_reg <= !irq_active;
    end
    else
    begin
      out_reg <= wave_reg;
      oe_n_reg <= wave_reg;
    end
  end

  assign irq_wave_out_n_o = out_reg;
  assign irq_wave_out_n_oe_n = oe_n_reg;

  // Registered read data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_reg <= '0;
    end
    else if (reg_rd)
    begin
      if (reg_addr >= ALM1_SEC_ADDR && reg_addr <= ALM2_DAY_ADDR)
      begin
        rdata_reg <= alarm_reg[alm_idx];
      end
      else if (reg_addr == CTRL_ADDR)
      begin
        rdata_reg <= {ctrl_reg[7:6], temp_convert_request_user_reg, ctrl_reg[4:0]};
      end
      else if (reg_addr == STAT_ADDR)
      begin
        rdata_reg <= {5'h00, temp_convert_request_state_reg != CV_IDLE, alarm2_flag_reg, alarm1_flag_reg};
      end
      else
      begin
        rdata_reg <= '0;
      end
    end
  end

  assign reg_rdata = rdata_reg;

  // Compensation seen since the last second pulse, for the rate check
  always_ff @(posedge clk)
  begin
    if (rst || sec_tick)
    begin
      comp_seen_reg <= 1'b0;
    end
    else if (comp_update_reg)
    begin
      comp_seen_reg <= 1'b1;
    end
  end

  a_flag_on_match: assert property (@(posedge clk) disable iff (rst) // [R3]
    eval_reg && osc_run && alarm1_hit && !ctrl_reg[CTRL_ALARM1_IRQ_ENABLE_BIT] |=> alarm1_flag_reg)
    else $error("alarm 1 match did not set flag");
  a_flag_only_eval: assert property (@(posedge clk) disable iff (rst) // [R4]
    $rose(alarm2_flag_reg) |-> $past(eval_reg) && $past(alarm2_hit))
    else $error("alarm 2 flag set outside update");
  a_osc_freeze: assert property (@(posedge clk) disable iff (rst) // [R9]
    !osc_run ##1 !osc_run |-> $stable(half_cnt_reg) && $stable(wave_reg))
    else $error("time base moved while stopped");
  a_temp_convert_request_bit_held: assert property (@(posedge clk) disable iff (rst) // [R11]
    temp_convert_request_user_reg && temp_convert_request_state_reg != CV_USER |=> temp_convert_request_user_reg)
    else $error("conversion bit dropped early");
  a_temp_convert_request_bit_clear: assert property (@(posedge clk) disable iff (rst) // [R11]
    temp_convert_request_state_reg == CV_USER && sensor_done |=> !temp_convert_request_user_reg && temp_convert_request_state_reg == CV_IDLE)
    else $error("conversion bit not cleared at end");
  a_comp_rate: assert property (@(posedge clk) disable iff (rst) // [R12]
    comp_update_reg |-> !comp_seen_reg)
    else $error("compensation ran twice in a second");
  a_flag_write_one: assert property (@(posedge clk) disable iff (rst) // [R18]
    wr_stat && reg_wdata[STAT_A1F_BIT] && !(eval_reg && alarm1_hit)
    |=> alarm1_flag_reg == $past(alarm1_flag_reg))
    else $error("write of one changed alarm 1 flag");
  a_irq_drive: assert property (@(posedge clk) disable iff (rst) // [R17]
    alarm1_flag_reg && ctrl_reg[CTRL_ALARM1_IRQ_ENABLE_BIT] && ctrl_reg[CTRL_IRQ_OR_WAVE_SELECT_BIT] && !batt_sync_reg
    |=> !irq_wave_out_n_oe_n && !irq_wave_out_n_o)
    else $error("enabled alarm 1 flag did not interrupt");
  a_irq_quiet: assert property (@(posedge clk) disable iff (rst) // [R16]
    ctrl_reg[CTRL_IRQ_OR_WAVE_SELECT_BIT] && !(alarm2_flag_reg && ctrl_reg[CTRL_ALARM2_IRQ_ENABLE_BIT])
    && !(alarm1_flag_reg && ctrl_reg[CTRL_ALARM1_IRQ_ENABLE_BIT]) |=> irq_wave_out_n_oe_n)
    else $error("interrupt without enabled flag");
  a_wave_mode: assert property (@(posedge clk) disable iff (rst) // [R14]
    !ctrl_reg[CTRL_IRQ_OR_WAVE_SELECT_BIT] && !batt_sync_reg |=> irq_wave_out_n_oe_n == $past(wave_reg))
    else $error("square wave not on output");
  a_batt_float: assert property (@(posedge clk) disable iff (rst) // [R10]
    batt_sync_reg && !ctrl_reg[CTRL_BBW_BIT] |=> irq_wave_out_n_oe_n)
    else $error("output driven on battery without enable");

  c_alarm1_fire: cover property (@(posedge clk) disable iff (rst)
    eval_reg && alarm1_hit ##1 !irq_wave_out_n_oe_n);
  c_user_temp_convert_request: cover property (@(posedge clk) disable iff (rst)
    temp_convert_request_state_reg == CV_USER && sensor_done);
  c_flag_clear: cover property (@(posedge clk) disable iff (rst)
    alarm2_flag_reg ##1 !alarm2_flag_reg);
endmodule
`default_nettype wire

// >>> bench/rtcam_partner.sv
// Calendar counter and temperature sensor models beside the alarm block
`default_nettype none
module rtcam_partner
  import rtcam_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Calendar
  input wire logic sec_tick,
  output logic [7:0] cur_seconds,
  output logic [7:0] cur_minutes,
  // Sensor, slow stretches the conversion
  input wire logic slow,
  input wire logic sensor_start,
  output logic sensor_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v == 8'h59)
      return 8'h00;
    if (v[3:0] == 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    return v + 8'h01;
  endfunction
  // Time moves only on the second pulse
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur_seconds <= 8'h50;
      cur_minutes <= 8'h00;
    end
    else if (sec_tick)
    begin
      cur_seconds <= bcd_inc(cur_seconds);
      if (cur_seconds == 8'h59)
        cur_minutes <= bcd_inc(cur_minutes);
    end
  end
  // Done only for a conversion in flight
  always_ff @(posedge clk)
  begin
    sensor_done <= 1'b0;
    if (rst)
      cnt <= 0;
    else if (sensor_start)
      cnt <= slow ? 5 : 2;
    else if (cnt == 1)
    begin
      sensor_done <= 1'b1;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the alarm match and control block
`default_nettype none
module tb
  import rtcam_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] mk = 8'h80;
  localparam logic [7:0] nx = 8'h7e;
  localparam logic [7:0] z0 = 8'h00;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, on_battery = 0, slow = 0, rd_d = 0;
  logic [4:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, cur_seconds, cur_minutes, ctl;
  logic sec_tick, osc_run, sensor_start, sensor_done, comp_update, pin_o, pin_oe_n;
  logic [1:0] flags;
  logic [7:0] exp_q[$];
  int num_errors = 0, n_checks = 0, seed = 27289, ncomp = 0;
  always #10 clk = ~clk;
  rtcam_alarm_ctrl #(.HALF_SEC_COUNT(8)) rtcam_alarm_ctrl_i (.clk(clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .cur_seconds(cur_seconds), .cur_minutes(cur_minutes),
    .cur_hours(8'h12), .cur_day(8'h03), .cur_date(8'h15), .sec_tick(sec_tick),
    .osc_run(osc_run), .on_battery(on_battery), .sensor_start(sensor_start),
    .sensor_done(sensor_done), .comp_update(comp_update), .irq_wave_out_n_o(pin_o),
    .irq_wave_out_n_oe_n(pin_oe_n));
  rtcam_partner rtcam_partner_i (.clk(clk), .rst(rst), .sec_tick(sec_tick),
    .cur_seconds(cur_seconds), .cur_minutes(cur_minutes), .slow(slow),
    .sensor_start(sensor_start), .sensor_done(sensor_done));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("[ERR] %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [4:0] ad, input logic [7:0] d);
    @(negedge clk);
    reg_addr = ad;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [4:0] ad, input logic [7:0] e);
    @(negedge clk);
    reg_addr = ad;
    reg_rd = 1;
    exp_q.push_back(e);
    @(negedge clk);
    reg_rd = 0;
  endtask
  task automatic wctl(input logic [7:0] d);
    ctl = d | (8'($random(seed)) & 8'h18);
    wr(CTRL_ADDR, ctl);
  endtask
  task automatic tick_wait(input int off);
    @(posedge clk iff sec_tick === 1'b1);
    repeat (off) @(negedge clk);
  endtask
  // Count level changes of the pin or of the second pulse
  task automatic cnt(input logic sel, input int n, input int e);
    logic p;
    int t;
    repeat (4) @(negedge clk);
    t = 0;
    p = sel ? sec_tick : pin_oe_n;
    repeat (n)
    begin
      @(negedge clk);
      if ((sel ? sec_tick : pin_oe_n) !== p)
        t++;
      p = sel ? sec_tick : pin_oe_n;
    end
    check(8'(t), 8'(e));
  endtask
  function automatic logic hit(input logic [7:0] s, m, h, d);
    logic [5:0] dd;
    dd = d[DYDT_BIT] ? 6'h03 : 6'h15;
    return (s[7] || s[6:0] == cur_seconds[6:0]) && (m[7] || m[6:0] == cur_minutes[6:0])
      && (h[7] || h[6:0] == 7'h12) && (d[7] || d[5:0] == dd);
  endfunction
  task automatic run_cfg(input logic [7:0] b[7], input logic [7:0] c, input int n);
    logic [7:0] mn;
    mn = cur_seconds < 8'h27 ? cur_minutes : rtcam_partner_i.bcd_inc(cur_minutes);
    foreach (b[i])
    begin
      if (b[i] == nx)
        b[i] = i < 4 ? mn : rtcam_partner_i.bcd_inc(cur_minutes);
      wr(ALM_BASE_ADDR + 5'(i), b[i]);
    end
    wctl(c);
    tick_wait(3);
    wr(STAT_ADDR, z0);
    flags = 2'b00;
    repeat (n)
    begin
      tick_wait(8);
      flags |= {hit(ALM2_SECONDS, b[4], b[5], b[6]), hit(b[0], b[1], b[2], b[3])};
      rd(STAT_ADDR, {6'h00, flags});
      check(pin_oe_n, !(c[2] && |(flags & c[1:0])));
      check(pin_o, !(c[2] && |(flags & c[1:0])));
    end
    $display("test alarm config %h done", c);
  endtask
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    if (sec_tick === 1'b1)
    begin
      check(8'(ncomp > 1), z0);
      ncomp = 0;
    end
    if (comp_update === 1'b1)
      ncomp++;
  end
  always @(negedge clk)
    if (rd_d === 1'b1)
      check(reg_rdata, exp_q.pop_front());
  initial
  begin
    #1000000;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 0;
    check(pin_oe_n, 1);
    check(osc_run, 1);
    rd(CTRL_ADDR, CTRL_RESET);
    rd(STAT_ADDR, z0);
    for (int i = 7; i < 14; i++)
      rd(5'(i), ALM_RESET);
    wr(5'h10, 8'($random(seed)));
    rd(5'h10, z0);
    $display("test reset done");
    tick_wait(6);
    slow = 1;
    wctl(8'h24);
    rd(CTRL_ADDR, ctl);
    @(posedge clk iff sensor_done === 1'b1);
    rd(STAT_ADDR, z0);
    rd(CTRL_ADDR, ctl & 8'hdf);
    slow = 0;
    $display("test conversion done");
    wctl(8'h80);
    cnt(1, 64, 8);
    on_battery = 1;
    cnt(1, 64, 0);
    check(osc_run, 0);
    wctl(8'h00);
    cnt(0, 32, 0);
    check(pin_oe_n, 1);
    wctl(8'h40);
    cnt(0, 64, 8);
    on_battery = 0;
    wctl(8'h00);
    cnt(0, 64, 8);
    $display("test power and wave done");
    run_cfg('{mk, mk, mk, mk, mk, mk, mk}, 8'h07, 3);
    run_cfg('{8'h30, mk, mk, mk, z0, z0, z0}, 8'h05, 62);
    run_cfg('{8'h30, nx, mk, mk, z0, z0, z0}, 8'h04, 62);
    run_cfg('{8'h30, nx, 8'h12, mk, z0, z0, z0}, 8'h05, 62);
    run_cfg('{8'h30, nx, 8'h12, 8'h15, z0, z0, z0}, 8'h05, 62);
    wr(STAT_ADDR, 8'h03);
    rd(STAT_ADDR, {6'h00, flags});
    wr(STAT_ADDR, z0);
    rd(STAT_ADDR, z0);
    check(pin_oe_n, 1);
    run_cfg('{8'h30, nx, 8'h12, 8'h43, nx, 8'h12, 8'h03}, 8'h07, 62);
    run_cfg('{z0, z0, z0, z0, mk, mk, mk}, 8'h06, 62);
    run_cfg('{z0, z0, z0, z0, nx, mk, mk}, 8'h04, 62);
    run_cfg('{z0, z0, z0, z0, nx, 8'h12, mk}, 8'h06, 62);
    run_cfg('{z0, z0, z0, z0, nx, 8'h12, 8'h43}, 8'h06, 62);
    repeat (4) @(negedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
